/* File: rtl/cfg_protect_pkg.sv */
// Constants for the program-memory protection and identification block.
// Assumes a single 25 MHz clock and a synchronous active-high reset.
package cfg_protect_pkg;
   localparam int ADDR_W = 16;
   localparam int WORD_W = 14;
   localparam logic [ADDR_W-1:0] USER_ID_FIRST = 16'h8000;
   localparam logic [ADDR_W-1:0] USER_ID_LAST = 16'h8003;
   localparam logic [ADDR_W-1:0] REVISION_CODE_OFS = 16'h8005;
   localparam logic [ADDR_W-1:0] PART_CODE_OFS = 16'h8006;
   localparam logic [ADDR_W-1:0] CFG_WORD1_OFS = 16'h8007;
   localparam logic [ADDR_W-1:0] CFG_WORD2_OFS = 16'h8008;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 16'h8010;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 16'h8011;
   localparam logic [ADDR_W-1:0] BOOT_END_4K = 16'h01FF;
   localparam logic [ADDR_W-1:0] HALF_END_4K = 16'h07FF;
   localparam logic [ADDR_W-1:0] LAST_4K = 16'h0FFF;
   localparam logic [ADDR_W-1:0] HALF_END_8K = 16'h0FFF;
   localparam logic [ADDR_W-1:0] LAST_8K = 16'h1FFF;
   localparam int LOCK_SEL_POS = 0;
   localparam int LOCK_N_POS = 7;
   localparam int OSC_SEL_POS = 0;
   localparam logic [1:0] LOCK_OFF = 2'h3;
   localparam logic [1:0] LOCK_BOOT = 2'h2;
   localparam logic [1:0] LOCK_HALF = 2'h1;
   localparam logic [1:0] LOCK_ALL = 2'h0;
   localparam logic [WORD_W-1:0] CFG_BLANK = 14'h3FFF;
   localparam logic [WORD_W-1:0] WORD_RESET = 14'h0000;
   localparam logic [1:0] CLK_SRC_RESET = 2'h0;
   localparam logic [1:0] INT_FREQ_RESET = 2'h2;
   typedef enum logic [3:0]
   {
      INTERNAL_OSC_MODE = 4'h1,
      EXT_CLK_LOW_POWER = 4'h2,
      EXT_CLK_MID_POWER = 4'h4,
      EXT_CLK_HIGH_POWER = 4'h8
   } clk_mode_e;
endpackage : cfg_protect_pkg

/* File: rtl/write_range_check.sv */
// Decides whether a self-write address falls in the locked range.
// Assumes a latched lock selection and array size from the main block.
`timescale 1ns/1ps
module write_range_check
(
   // Configuration.
   input wire logic [1:0] self_write_lock_sel_i,
   input wire logic big_array_i,
   // Address under test.
   input wire logic [cfg_protect_pkg::ADDR_W-1:0] addr_i,
   // Result.
   output logic blocked_o
);
   import cfg_protect_pkg::*;
   logic [ADDR_W-1:0] last_word;
   logic [ADDR_W-1:0] lock_end;
   logic in_array;
   logic lock_any;
   assign last_word = big_array_i ? LAST_8K : LAST_4K;
   assign in_array = (addr_i <= last_word);
   always_comb
   begin
      lock_any = 1'b1;
      lock_end = last_word;
      case (self_write_lock_sel_i)
         LOCK_OFF:
         begin
            lock_any = 1'b0;
         end
         LOCK_BOOT:
         begin
            lock_end = BOOT_END_4K;
         end
         LOCK_HALF:
         begin
            lock_end = big_array_i ? HALF_END_8K : HALF_END_4K;
         end
         default:
         begin
            lock_end = last_word;
         end
      endcase
   end
   assign blocked_o = in_array & lock_any & (addr_i <= lock_end);
endmodule : write_range_check

/* File: rtl/config_memory_protection.sv */
// Program memory with configuration-driven write lock, external access lock,
// identification words and reset-default clock mode selection.
// Assumes one 25 MHz clock, synchronous active-high reset, and a CPU and an
// external programmer port that both run on that clock.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module config_memory_protection
#(
   parameter logic BIG_ARRAY = 1'b0,
   // Arbitrary neutral identification values.
   parameter logic [cfg_protect_pkg::WORD_W-1:0] PART_CODE = 14'h0A5A,
   parameter logic [cfg_protect_pkg::WORD_W-1:0] REVISION_CODE = 14'h0101
)
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic reset_i,
   // CPU register and memory port.
   input wire logic [cfg_protect_pkg::ADDR_W-1:0] addr_i,
   input wire logic [cfg_protect_pkg::WORD_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [cfg_protect_pkg::WORD_W-1:0] rdata_o,
   // External programmer port.
   input wire logic [cfg_protect_pkg::ADDR_W-1:0] prog_addr_i,
   input wire logic [cfg_protect_pkg::WORD_W-1:0] prog_wdata_i,
   input wire logic prog_wr_i,
   input wire logic prog_rd_i,
   input wire logic prog_bulk_erase_i,
   output logic [cfg_protect_pkg::WORD_W-1:0] prog_rdata_o,
   // Status outputs.
   output logic [3:0] clk_mode_o,
   output logic [1:0] sys_clk_src_o,
   output logic [1:0] int_osc_sel_o,
   output logic write_blocked_o,
   output logic external_access_lock_n_o
);
   import cfg_protect_pkg::*;

   localparam int MEM_DEPTH = 8192;

   logic [WORD_W-1:0] mem [0:MEM_DEPTH-1];
   logic [WORD_W-1:0] user_id [0:3];
   logic [WORD_W-1:0] cfg_word1;
   logic [WORD_W-1:0] cfg_word2;
   logic [1:0] self_write_lock_sel;
   logic external_access_lock_n;
   clk_mode_e clk_mode;
   clk_mode_e next_clk_mode;
   logic [1:0] sys_clk_src;
   logic [1:0] int_osc_sel;
   logic write_blocked;
   logic [WORD_W-1:0] rdata;
   logic [WORD_W-1:0] prog_rdata;
   logic latched;
   logic [ADDR_W-1:0] prog_addr_s1;
   logic [ADDR_W-1:0] prog_addr_s2;
   logic [WORD_W-1:0] prog_wdata_s1;
   logic [WORD_W-1:0] prog_wdata_s2;
   logic [2:0] prog_ctl_s1;
   logic [2:0] prog_ctl_s2;
   logic [2:0] prog_ctl_d;
   logic prog_wr_p;
   logic prog_rd_p;
   logic prog_erase_p;

   wire cpu_blocked;
   wire in_mem = (addr_i < ADDR_W'(MEM_DEPTH)) &&
      (BIG_ARRAY || addr_i <= LAST_4K);
   wire in_user = (addr_i >= USER_ID_FIRST) && (addr_i <= USER_ID_LAST);
   wire prog_in_mem = (prog_addr_s2 < ADDR_W'(MEM_DEPTH)) &&
      (BIG_ARRAY || prog_addr_s2 <= LAST_4K);
   wire prog_in_user = (prog_addr_s2 >= USER_ID_FIRST) &&
      (prog_addr_s2 <= USER_ID_LAST);
   wire cpu_mem_wr = wr_i && in_mem && !cpu_blocked;
   wire prog_open = external_access_lock_n;
   wire prog_mem_wr = prog_wr_p && prog_open && prog_in_mem;

   // Reads the word or register at an address for the CPU or the programmer port.
   function automatic logic [WORD_W-1:0] fetch
   (
      input logic [ADDR_W-1:0] a
   );
      logic [WORD_W-1:0] v;
      v = WORD_RESET;
      if (a <= LAST_8K && (BIG_ARRAY || a <= LAST_4K))
      begin
         v = mem[a[12:0]];
      end
      else if (a >= USER_ID_FIRST && a <= USER_ID_LAST)
      begin
         v = user_id[a[1:0]];
      end
      else if (a == REVISION_CODE_OFS)
      begin
         v = REVISION_CODE;
      end
      else if (a == PART_CODE_OFS)
      begin
         v = PART_CODE;
      end
      else if (a == CFG_WORD1_OFS)
      begin
         v = cfg_word1;
      end
      else if (a == CFG_WORD2_OFS)
      begin
         v = cfg_word2;
      end
      else if (a == CTRL_OFS)
      begin
         v = {8'h00, int_osc_sel, 2'h0, sys_clk_src};
      end
      else if (a == STATUS_OFS)
      begin
         v = {8'h00, write_blocked, external_access_lock_n, clk_mode};
      end
      return v;
   endfunction : fetch

   // Compares each CPU self-write address with the latched lock range.
   write_range_check u_range
   (
      .self_write_lock_sel_i(self_write_lock_sel),
      .big_array_i(BIG_ARRAY),
      .addr_i(addr_i),
      .blocked_o(cpu_blocked)
   );

   always_comb
   begin
      case (cfg_word1[OSC_SEL_POS +: 2])
         2'h3: next_clk_mode = EXT_CLK_HIGH_POWER;
         2'h2: next_clk_mode = EXT_CLK_MID_POWER;
         2'h1: next_clk_mode = EXT_CLK_LOW_POWER;
         default: next_clk_mode = INTERNAL_OSC_MODE;
      endcase
   end

   assign prog_wr_p = prog_ctl_s2[0] & ~prog_ctl_d[0];
   assign prog_rd_p = prog_ctl_s2[1] & ~prog_ctl_d[1];
   assign prog_erase_p = prog_ctl_s2[2] & ~prog_ctl_d[2];

   // Programmer port pins pass two flip-flops before use.
   always_ff @(posedge clk_i)
   begin
      prog_addr_s1 <= prog_addr_i;
      prog_addr_s2 <= prog_addr_s1;
      prog_wdata_s1 <= prog_wdata_i;
      prog_wdata_s2 <= prog_wdata_s1;
      prog_ctl_s1 <= {prog_bulk_erase_i, prog_rd_i, prog_wr_i};
      prog_ctl_s2 <= prog_ctl_s1;
      if (reset_i)
      begin
         prog_ctl_d <= 3'h0;
      end
      else
      begin
         prog_ctl_d <= prog_ctl_s2;
      end
   end

   // Configuration words live in nonvolatile storage; only the programmer
   // or a bulk erase changes them.
   always_ff @(posedge clk_i)
   begin
      if (prog_erase_p)
      begin
         cfg_word1 <= CFG_BLANK;
         cfg_word2 <= CFG_BLANK;
      end
      else if (prog_wr_p && prog_addr_s2 == CFG_WORD1_OFS)
      begin
         cfg_word1 <= prog_wdata_s2 & (prog_open ? CFG_BLANK :
            ~(WORD_W'(1) << LOCK_N_POS));
      end
      else if (prog_wr_p && prog_open && prog_addr_s2 == CFG_WORD2_OFS)
      begin
         cfg_word2 <= prog_wdata_s2;
      end
   end

   // Protection and clock mode are captured in the first cycle after reset.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         latched <= 1'b0;
         self_write_lock_sel <= LOCK_ALL;
         external_access_lock_n <= 1'b0;
         clk_mode <= INTERNAL_OSC_MODE;
      end
      else if (!latched)
      begin
         latched <= 1'b1;
         self_write_lock_sel <= cfg_word2[LOCK_SEL_POS +: 2];
         external_access_lock_n <= cfg_word1[LOCK_N_POS] | prog_erase_p;
         clk_mode <= next_clk_mode;
      end
      else if (prog_erase_p)
      begin
         external_access_lock_n <= 1'b1;
      end
   end

   // Run-time clock selection and write status.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         sys_clk_src <= CLK_SRC_RESET;
         int_osc_sel <= INT_FREQ_RESET;
         write_blocked <= 1'b0;
      end
      else
      begin
         if (wr_i && addr_i == CTRL_OFS)
         begin
            sys_clk_src <= wdata_i[1:0];
            int_osc_sel <= wdata_i[5:4];
         end
         if (wr_i && addr_i < USER_ID_FIRST)
         begin
            write_blocked <= cpu_blocked;
         end
      end
   end

   // Program memory and user ID words.
   always_ff @(posedge clk_i)
   begin
      if (cpu_mem_wr)
      begin
         mem[addr_i[12:0]] <= wdata_i;
      end
      else if (prog_mem_wr)
      begin
         mem[prog_addr_s2[12:0]] <= prog_wdata_s2;
      end
      if (wr_i && in_user)
      begin
         user_id[addr_i[1:0]] <= wdata_i;
      end
      else if (prog_wr_p && prog_open && prog_in_user)
      begin
         user_id[prog_addr_s2[1:0]] <= prog_wdata_s2;
      end
   end

   // Read answers, one cycle after the CPU strobe and three cycles after the programmer strobe pin rises.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         rdata <= WORD_RESET;
         prog_rdata <= WORD_RESET;
      end
      else
      begin
         if (rd_i)
         begin
            rdata <= fetch(addr_i);
         end
         if (prog_rd_p)
         begin
            prog_rdata <= (prog_open || !(prog_in_mem || prog_in_user)) ?
               fetch(prog_addr_s2) : WORD_RESET;
         end
      end
   end

   assign rdata_o = rdata;
   assign prog_rdata_o = prog_rdata;
   assign clk_mode_o = clk_mode;
   assign sys_clk_src_o = sys_clk_src;
   assign int_osc_sel_o = int_osc_sel;
   assign write_blocked_o = write_blocked;
   assign external_access_lock_n_o = external_access_lock_n;
endmodule : config_memory_protection

/* File: tb/protect_assertions.sv */
// Checker for the protection block, watching only its ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module protect_assertions
#(
   parameter logic BIG_ARRAY = 1'b0,
   parameter logic [13:0] PART_CODE = 14'h0A5A,
   parameter logic [13:0] REVISION_CODE = 14'h0101
)
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic reset_i,
   // CPU port.
   input wire logic [15:0] addr_i,
   input wire logic [13:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [13:0] rdata_o,
   // Programmer port.
   input wire logic [15:0] prog_addr_i,
   input wire logic prog_rd_i,
   input wire logic [13:0] prog_rdata_o,
   // Status.
   input wire logic [3:0] clk_mode_o,
   input wire logic [1:0] sys_clk_src_o,
   input wire logic [1:0] int_osc_sel_o,
   input wire logic write_blocked_o,
   input wire logic external_access_lock_n_o
);
   import cfg_protect_pkg::*;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   logic [13:0] wd_q;
   always_ff @(posedge clk_i)
   begin
      wd_q <= wdata_i;
   end
   sequence s_settled;
      !reset_i && !$past(reset_i) && !$past(reset_i, 2);
   endsequence
   sequence s_locked_rd;
      !external_access_lock_n_o && prog_addr_i <= USER_ID_LAST
         && $rose(prog_rd_i);
   endsequence
   property p_part;
      rd_i && addr_i == PART_CODE_OFS |=> rdata_o == PART_CODE;
   endproperty
   property p_rev;
      rd_i && addr_i == REVISION_CODE_OFS |=> rdata_o == REVISION_CODE;
   endproperty
   property p_onehot;
      $onehot(clk_mode_o);
   endproperty
   property p_mode_hold;
      s_settled |-> $stable(clk_mode_o);
   endproperty
   property p_lock_hold;
      s_settled |-> !$fell(external_access_lock_n_o);
   endproperty
   property p_locked_rd;
      s_locked_rd |-> ##5 prog_rdata_o == 14'h0000;
   endproperty
   property p_status;
      rd_i && addr_i == STATUS_OFS |=> rdata_o[3:0] == clk_mode_o
         && rdata_o[4] == external_access_lock_n_o;
   endproperty
   property p_ctrl;
      wr_i && addr_i == CTRL_OFS |=> sys_clk_src_o == wd_q[1:0]
         && int_osc_sel_o == wd_q[5:4];
   endproperty
   property p_outside;
      wr_i && !BIG_ARRAY && addr_i > LAST_4K && addr_i < USER_ID_FIRST
         |=> !write_blocked_o;
   endproperty
   property p_wb_hold;
      !wr_i |=> $stable(write_blocked_o);
   endproperty
   a_part: assert property (p_part) else $error("part code");
   a_rev: assert property (p_rev) else $error("revision");
   a_onehot: assert property (p_onehot) else $error("mode");
   a_mode_hold: assert property (p_mode_hold) else $error("mode");
   a_lock_hold: assert property (p_lock_hold) else $error("lock");
   a_locked_rd: assert property (p_locked_rd) else $error("read");
   a_status: assert property (p_status) else $error("status");
   a_ctrl: assert property (p_ctrl) else $error("control");
   a_outside: assert property (p_outside) else $error("outside");
   a_wb_hold: assert property (p_wb_hold) else $error("blocked");
endmodule : protect_assertions
bind config_memory_protection protect_assertions #(.BIG_ARRAY(BIG_ARRAY),
   .PART_CODE(PART_CODE), .REVISION_CODE(REVISION_CODE)) i_chk
(
   .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .prog_addr_i(prog_addr_i),
   .prog_rd_i(prog_rd_i), .prog_rdata_o(prog_rdata_o),
   .clk_mode_o(clk_mode_o), .sys_clk_src_o(sys_clk_src_o),
   .int_osc_sel_o(int_osc_sel_o), .write_blocked_o(write_blocked_o),
   .external_access_lock_n_o(external_access_lock_n_o)
);

/* File: tb/prog_model.sv */
// Programmer model for the external programming port.
// Assumes the device syncs the strobes on clk_i.
`timescale 1ns/1ps
module prog_model
(
   // Clock.
   input wire logic clk_i,
   // Programming pins.
   output logic [15:0] addr_o,
   output logic [13:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   output logic erase_o,
   input wire logic [13:0] rdata_i
);
   initial
   begin
      addr_o = 16'h0000;
      wdata_o = 14'h0000;
      {wr_o, rd_o, erase_o} = 3'h0;
   end
   // Kind 0 writes, 1 reads, 2 erases; pins held around the strobe.
   task automatic op(input logic [15:0] a, input logic [13:0] d,
      input int k, output logic [13:0] q);
      addr_o <= a;
      wdata_o <= d;
      repeat (2) @(posedge clk_i);
      wr_o <= (k == 0);
      rd_o <= (k == 1);
      erase_o <= (k == 2);
      repeat (5) @(posedge clk_i);
      q = rdata_i;
      {wr_o, rd_o, erase_o} <= 3'h0;
      repeat (3) @(posedge clk_i);
   endtask : op
   // A blank part code names no part.
   function automatic logic part_valid(input logic [13:0] v);
      return v !== 14'h3FFF;
   endfunction : part_valid
endmodule : prog_model

/* File: tb/testbench.sv */
// Self-checking bench for the protection block on the 4K array, with an 8K copy checked for write blocking.
// Assumes configuration is programmed between two resets.
`timescale 1ns/1ps
module testbench;
   import cfg_protect_pkg::*;
   localparam logic [13:0] PART = 14'h1234; // Arbitrary value.
   localparam logic [13:0] REV = 14'h0042; // Arbitrary value.
   localparam logic [15:0] EDGES [6] = '{16'h0000, 16'h01FF, 16'h0200,
      16'h07FF, 16'h0800, 16'h0FFF};
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [15:0] addr_i = 16'h0000;
   logic [13:0] wdata_i = 14'h0000;
   logic [15:0] pa, addrs [22];
   logic [13:0] rdata_o, pd, pq, r, d, e, exp_mem [4096];
   logic pw, pr, pe, wb, wb8, e8, lock_n;
   logic [3:0] clk_mode_o;
   logic [1:0] src, osc, code;
   int failures = 0;
   int checks = 0;
   always #20 clk_i = ~clk_i;
   config_memory_protection #(.PART_CODE(PART), .REVISION_CODE(REV)) i_dut
   (
      .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .prog_addr_i(pa),
      .prog_wdata_i(pd), .prog_wr_i(pw), .prog_rd_i(pr),
      .prog_bulk_erase_i(pe), .prog_rdata_o(pq), .clk_mode_o(clk_mode_o),
      .sys_clk_src_o(src), .int_osc_sel_o(osc), .write_blocked_o(wb),
      .external_access_lock_n_o(lock_n)
   );
   config_memory_protection #(.BIG_ARRAY(1'b1)) i_dut8
   (
      .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(), .prog_addr_i(pa),
      .prog_wdata_i(pd), .prog_wr_i(pw), .prog_rd_i(pr),
      .prog_bulk_erase_i(pe), .prog_rdata_o(), .clk_mode_o(),
      .sys_clk_src_o(), .int_osc_sel_o(), .write_blocked_o(wb8),
      .external_access_lock_n_o()
   );
   prog_model i_prog
   (
      .clk_i(clk_i), .addr_o(pa), .wdata_o(pd), .wr_o(pw), .rd_o(pr),
      .erase_o(pe), .rdata_i(pq)
   );
   task automatic chk(input string n, input logic [13:0] x, input logic [13:0] s);
      checks++;
      if (s !== x)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic cpu_wr(input logic [15:0] a, input logic [13:0] v);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask : cpu_wr
   task automatic cpu_rd(input logic [15:0] a, output logic [13:0] v);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
      v = rdata_o;
   endtask : cpu_rd
   function automatic logic blk(input logic [1:0] c, input logic [15:0] a);
      case (c)
         LOCK_BOOT: return a <= BOOT_END_4K;
         LOCK_HALF: return a <= HALF_END_4K;
         LOCK_ALL: return a <= LAST_4K;
         default: return 1'b0;
      endcase
   endfunction : blk
   task automatic close_out();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   initial
   begin
      void'($urandom(67411));
      foreach (addrs[i])
         addrs[i] = (i < 6) ? EDGES[i] : 16'($urandom_range(0, 4095));
      for (int c = 3; c >= 0; c--)
      begin
         code = 2'(c);
         reset_i <= 1'b1;
         repeat (16) @(posedge clk_i);
         reset_i <= 1'b0;
         repeat (2) @(posedge clk_i);
         i_prog.op(16'h0000, 14'h0000, 2, r);
         i_prog.op(CFG_WORD2_OFS, {12'hFFF, code}, 0, r);
         i_prog.op(CFG_WORD1_OFS, {6'h3F, code != 2'h0, 5'h1F, code}, 0, r);
         reset_i <= 1'b1;
         repeat (16) @(posedge clk_i);
         reset_i <= 1'b0;
         repeat (2) @(posedge clk_i);
         chk("mode", 14'(4'h1 << code), 14'(clk_mode_o));
         chk("lock_n", 14'(code != 2'h0), 14'(lock_n));
         foreach (addrs[i])
         begin
            d = 14'($urandom);
            e = 14'(blk(code, addrs[i]));
            cpu_wr(addrs[i], d);
            chk("blocked", e, 14'(wb));
            e8 = blk(code, addrs[i]) || code <= LOCK_HALF;
            chk("blocked 8k", 14'(e8), 14'(wb8));
            if (e == 14'h0000)
               exp_mem[addrs[i][11:0]] = d;
            cpu_rd(addrs[i], r);
            chk("memory", exp_mem[addrs[i][11:0]], r);
         end
         cpu_wr(16'h1000, d);
         chk("8k upper", 14'(code == LOCK_ALL), 14'(wb8));
         $display("test lock code %0d done", c);
      end
      i_prog.op(addrs[0], 14'h0000, 1, r);
      chk("locked read", 14'h0000, r);
      i_prog.op(addrs[6], ~exp_mem[addrs[6][11:0]], 0, r);
      cpu_rd(addrs[6], r);
      chk("locked write", exp_mem[addrs[6][11:0]], r);
      cpu_wr(16'h2000, 14'h1555);
      chk("outside", 14'h0000, 14'(wb));
      for (int i = 0; i < 4; i++)
      begin
         d = 14'($urandom);
         cpu_wr(USER_ID_FIRST + 16'(i), d);
         cpu_rd(USER_ID_FIRST + 16'(i), r);
         chk("user id", d, r);
         cpu_wr(CTRL_OFS, d);
         chk("source", 14'(d[1:0]), 14'(src));
         chk("osc", 14'(d[5:4]), 14'(osc));
      end
      cpu_wr(PART_CODE_OFS, ~PART);
      cpu_wr(REVISION_CODE_OFS, ~REV);
      cpu_rd(PART_CODE_OFS, r);
      chk("part", PART, r);
      cpu_rd(REVISION_CODE_OFS, r);
      chk("revision", REV, r);
      cpu_rd(16'h8020, r);
      chk("unmapped", 14'h0000, r);
      cpu_rd(STATUS_OFS, r);
      chk("status", 14'h0001, r);
      $display("test ids and control done");
      i_prog.op(16'h0000, 14'h0000, 2, r);
      chk("erase", 14'h0001, 14'(lock_n));
      i_prog.op(addrs[0], 14'h0000, 1, r);
      chk("open read", exp_mem[addrs[0][11:0]], r);
      i_prog.op(PART_CODE_OFS, 14'h0000, 1, r);
      chk("part valid", 14'(i_prog.part_valid(r)), 14'h0001);
      $display("test programmer done");
      close_out();
   end
   initial
   begin
      #2000000;
      failures++;
      close_out();
   end
endmodule : testbench
